/* File: src/afd_top.sv */
// filter mode and ratio decode with apb register slave
// assumes an apb master on ref_clk; all inputs are on that clock
//
// Our own choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
module afd_top
  import afd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic [1:0] filter_path,
  output logic first_stage_sinc3,
  output logic coef_programmable,
  output logic [17:0] eff_ratio,
  output logic [2:0] stage_bypass,
  output logic wideband_stage_order,
  output logic [2:0] start_delay,
  output logic sample_strobe
);
  // ==========================================================
  // register storage
  logic [7:0] filter_mode_select; // variant and ratio code
  logic [7:0] filter_stage_control; // delay, order, disables
  logic [7:0] speed_config; // speed mode in low two bits

  // ==========================================================
  // apb decode
  wire access = psel && penable; // access phase
  wire [5:0] idx = paddr[7:2]; // word index
  wire hit_mode = (idx == AFD_IDX_MODE);
  wire hit_stage = (idx == AFD_IDX_STAGE);
  wire hit_speed = (idx == AFD_IDX_SPEED);
  wire hit_status = (idx == AFD_IDX_STATUS);
  wire mapped = hit_mode || hit_stage || hit_speed || hit_status;
  // one wait state: answer is prepared while pready is low
  wire prep = access && !pready;
  // write lands only on the completing edge
  wire done = access && pready;
  wire wr_ok = done && pwrite && mapped && pstrb[0];
  wire wr_mode = wr_ok && hit_mode;
  wire wr_stage = wr_ok && hit_stage; // R11
  wire wr_speed = wr_ok && hit_speed;

  // ==========================================================
  // field decode
  wire [4:0] ratio_code = filter_mode_select[4:0];
  wire [2:0] variant = filter_mode_select[AFD_VAR_LSB +: 3];
  wire [1:0] speed = speed_config[1:0];
  wire fir2_off = filter_stage_control[AFD_FIR2_BIT]; // R12
  wire fir3_off = filter_stage_control[AFD_FIR3_BIT]; // R12
  wire iir_off = filter_stage_control[AFD_IIR_BIT]; // R12
  wire order_bit = filter_stage_control[AFD_ORDER_BIT]; // R12
  wire [2:0] delay_f = filter_stage_control[AFD_DELAY_LSB +: 3]; // R12

  // ==========================================================
  // mode decode from the top bits of the ratio code
  wire is_wide = (ratio_code[4:3] == 2'h0); // R4
  wire is_casc = (ratio_code[4:2] == 3'h7); // R10
  wire is_long = (ratio_code[4:2] == 3'h6); // R9
  wire [1:0] next_path;
  assign next_path = is_wide ? AFD_PATH_WIDE :
    is_casc ? AFD_PATH_CASC :
    is_long ? AFD_PATH_LONG :
    AFD_PATH_SINC; // R7 R8

  // ==========================================================
  // variant decode; reserved codes fall back to the 000 meaning
  // so the data path never sees an undefined setting
  wire next_coef = is_wide && (variant == AFD_VAR_PROG); // R1 R2 R16
  wire next_sinc3 = !is_wide && (variant == AFD_VAR_SINC3); // R1 R3 R16

  // ==========================================================
  // ratio: lookup then wideband reduction
  wire [17:0] base_ratio;
  afd_ratio_rom u_rom
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .code(ratio_code),
    .speed(speed),
    .base_ratio(base_ratio)
  );
  // each disabled fir section removes one decimate-by-two stage
  wire both_off = fir2_off && fir3_off;
  wire one_off = fir2_off ^ fir3_off;
  wire [17:0] wide_ratio = both_off ? (base_ratio >> 2) :
    one_off ? (base_ratio >> 1) : base_ratio; // R5 R14
  wire [17:0] next_ratio = is_wide ? wide_ratio : base_ratio;

  // ==========================================================
  // read mux, bits above each register read as zero
  wire [9:0] eff_ratio_hi = 10'h000; // status bits above the live decode
  wire [31:0] rd_status = {10'h000, next_coef, next_sinc3, next_path, next_ratio};
  wire [31:0] rd_word = hit_mode ? {24'h00_0000, filter_mode_select} :
    hit_stage ? {24'h00_0000, filter_stage_control} :
    hit_speed ? {24'h00_0000, speed_config} :
    hit_status ? {eff_ratio_hi, rd_status[21:0]} :
    32'h0000_0000;

  // ==========================================================
  // apb handshake flops
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end
    else
    begin
      pready <= prep;
      // unmapped words answer with an error and zero data
      pslverr <= prep && !mapped;
      if (prep)
        prdata <= pwrite ? 32'h0000_0000 : rd_word;
    end
  end

  // ==========================================================
  // mode select register
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      filter_mode_select <= AFD_MODE_RESET;
    else if (wr_mode)
      filter_mode_select <= pwdata[7:0];
  end

  // ==========================================================
  // stage control register, reserved bit 7 held at zero
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      filter_stage_control <= AFD_STAGE_RESET; // R11
    else if (wr_stage)
      filter_stage_control <= pwdata[7:0] & AFD_STAGE_MASK; // R12
  end

  // ==========================================================
  // speed mode register
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      speed_config <= AFD_SPEED_RESET;
    else if (wr_speed)
      speed_config <= pwdata[7:0] & AFD_SPEED_MASK;
  end

  // ==========================================================
  // decoded outputs, one edge behind the registers
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      filter_path <= AFD_PATH_WIDE;
      first_stage_sinc3 <= 1'b0;
      coef_programmable <= 1'b0;
      eff_ratio <= 18'h0_0020;
      stage_bypass <= 3'h1;
      wideband_stage_order <= 1'b0;
      start_delay <= 3'h0;
    end
    else
    begin
      filter_path <= next_path; // R17
      first_stage_sinc3 <= next_sinc3; // R17
      coef_programmable <= next_coef; // R17
      eff_ratio <= next_ratio; // R17
      stage_bypass <= {fir2_off, fir3_off, iir_off}; // R14
      wideband_stage_order <= order_bit;
      start_delay <= delay_f;
    end
  end

  // ==========================================================
  // sample strobe from the modulator rate
  // note: the first strobe after reset comes from the reset ratio
  afd_rate_gen u_rate
  (
    .ref_clk(ref_clk),
    .reset_n(reset_n),
    .ratio(eff_ratio),
    .mod_tick(),
    .sample_strobe(sample_strobe)
  );

  // ==========================================================
  // checks
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!reset_n);

  sequence s_stage_write;
    wr_stage && pwdata[2:0] != 3'h0;
  endsequence
  sequence s_bypass_follow;
    ##2 stage_bypass == $past(pwdata[2:0], 2);
  endsequence

  chk_stage_update: assert property (s_stage_write |-> s_bypass_follow) // R17
    else $error("stage outputs did not follow write");
  chk_path_wide: assert property (is_wide |=> filter_path == AFD_PATH_WIDE) // R4
    else $error("wideband code not decoded");
  chk_path_sinc: assert property
    ((ratio_code >= 5'h08 && ratio_code <= 5'h0d) |=> filter_path == AFD_PATH_SINC) // R7
    else $error("short sinc code not decoded");
  chk_path_casc: assert property (is_casc |=> filter_path == AFD_PATH_CASC) // R10
    else $error("cascade code not decoded");
  chk_half_ratio: assert property
    ((is_wide && one_off) |=> eff_ratio == ($past(base_ratio) >> 1)) // R5
    else $error("wideband ratio not halved");
  chk_quarter_ratio: assert property
    ((is_wide && both_off) |=> eff_ratio == ($past(base_ratio) >> 2)) // R5
    else $error("wideband ratio not quartered");
  chk_sinc3_sel: assert property
    ((!is_wide && variant == 3'h1) |=> first_stage_sinc3 && !coef_programmable) // R3
    else $error("sinc3 first stage not selected");
  chk_coef_prog: assert property
    ((is_wide && variant == 3'h7) |=> coef_programmable && !first_stage_sinc3) // R2
    else $error("programmable coefficients not selected");
  chk_reserved_zero: assert property (filter_stage_control[7] == 1'b0) // R12
    else $error("reserved stage bit set");
  chk_apb_wait: assert property (prep |=> pready ##1 !pready)
    else $error("apb answer not one wait state");
endmodule
`default_nettype wire

/* File: shared/afd_pkg.sv */
// constants, types and ratio tables for the filter mode and ratio decode
// assumes a single 100 MHz clock and an apb slave with 32-bit data
//
// What this block does
// R1: variant field meaning follows the filter mode
// R2: wideband 000 preset, 111 programmable coefficients
// R3: sinc 000 sinc4, 001 sinc3 first stage
// R4: codes 0 to 7 wideband, 32 to 4096
// R5: one fir off halves, both quarter ratio
// R6: samples at modulator rate over ratio
// R7: codes 8 to 13 sinc, fixed ratios
// R8: codes 14 to 23 sinc, mid-speed column
// R9: codes 24 to 27 sinc-only long ratios
// R10: codes 28 to 31 sinc plus sinc1 cascade
// R11: stage control at index 0Ah, resets 01h
// R12: stage control bit layout, bit 7 reserved
// R13: modulator rate is clock divided by two
// R14: disable bit set bypasses that section
// R15: speed mode 01 picks mid-speed ratios
// R16: reserved variant values act as 000
// R17: decoded outputs registered after register write
package afd_pkg;
  // ==========================================================
  // register indices, byte address is four times the index
  localparam logic [5:0] AFD_IDX_MODE = 6'h09;
  localparam logic [5:0] AFD_IDX_STAGE = 6'h0a;
  localparam logic [5:0] AFD_IDX_SPEED = 6'h20;
  localparam logic [5:0] AFD_IDX_STATUS = 6'h21;
  // ==========================================================
  // reset values and masks
  localparam logic [7:0] AFD_MODE_RESET = 8'h00;
  localparam logic [7:0] AFD_STAGE_RESET = 8'h01;
  localparam logic [7:0] AFD_STAGE_MASK = 8'h7f;
  localparam logic [7:0] AFD_SPEED_RESET = 8'h02;
  localparam logic [7:0] AFD_SPEED_MASK = 8'h03;
  // ==========================================================
  // field positions
  localparam int AFD_VAR_LSB = 5;
  localparam int AFD_DELAY_LSB = 4;
  localparam int AFD_ORDER_BIT = 3;
  localparam int AFD_FIR2_BIT = 2;
  localparam int AFD_FIR3_BIT = 1;
  localparam int AFD_IIR_BIT = 0;
  // ==========================================================
  // codes and counts
  localparam logic [2:0] AFD_VAR_PRESET = 3'h0;
  localparam logic [2:0] AFD_VAR_PROG = 3'h7;
  localparam logic [2:0] AFD_VAR_SINC3 = 3'h1;
  localparam logic [1:0] AFD_SPEED_MID = 2'h1;
  localparam int AFD_MOD_DIV = 2;
  localparam int AFD_RATIO_W = 18;
  // filter path kinds
  typedef enum logic [1:0]
  {
    AFD_PATH_WIDE = 2'h0,
    AFD_PATH_SINC = 2'h1,
    AFD_PATH_LONG = 2'h2,
    AFD_PATH_CASC = 2'h3
  } afd_path_t;
  // ==========================================================
  // base ratios per code, normal and mid-speed columns
  localparam logic [17:0] AFD_RATIO_NORM [0:31] = '{
    18'h0_0020, 18'h0_0040, 18'h0_0080, 18'h0_0100,
    18'h0_0200, 18'h0_0400, 18'h0_0800, 18'h0_1000,
    18'h0_000c, 18'h0_0010, 18'h0_0018, 18'h0_0020,
    18'h0_0040, 18'h0_0080, 18'h0_0100, 18'h0_014d,
    18'h0_0200, 18'h0_029b, 18'h0_0400, 18'h0_0535,
    18'h0_0800, 18'h0_0a6b, 18'h0_1000, 18'h0_14d5,
    18'h0_682b, 18'h0_7d00, 18'h1_7700, 18'h2_7100,
    18'h0_6820, 18'h0_7d00, 18'h1_7700, 18'h2_7100};
  localparam logic [17:0] AFD_RATIO_MID [0:31] = '{
    18'h0_0020, 18'h0_0040, 18'h0_0080, 18'h0_0100,
    18'h0_0200, 18'h0_0400, 18'h0_0800, 18'h0_1000,
    18'h0_000c, 18'h0_0010, 18'h0_0018, 18'h0_0020,
    18'h0_0040, 18'h0_0080, 18'h0_00a7, 18'h0_0100,
    18'h0_014d, 18'h0_0200, 18'h0_029b, 18'h0_0400,
    18'h0_0535, 18'h0_0800, 18'h0_0a6b, 18'h0_1000,
    18'h0_3415, 18'h0_3e80, 18'h0_bb80, 18'h1_3880,
    18'h0_3416, 18'h0_3e80, 18'h0_bb80, 18'h1_3880};
endpackage

/* File: src/afd_ratio_rom.sv */
// base oversampling ratio lookup with speed column select
// assumes code and speed come from registers on the same clock
`timescale 1ns/1ps
`default_nettype none
module afd_ratio_rom
  import afd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [4:0] code,
  input wire logic [1:0] speed,
  output logic [17:0] base_ratio
);
  // ==========================================================
  // column select
  wire mid_col = (speed == AFD_SPEED_MID); // R15
  // wideband and short sinc rows match in both columns
  assign base_ratio = mid_col ? AFD_RATIO_MID[code] : AFD_RATIO_NORM[code]; // R4 R7 R8 R9 R10
  // ==========================================================
  // checks
  chk_mid_column: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (mid_col && code == 5'h0e) |-> base_ratio == 18'h0_00a7) // R15
    else $error("mid-speed ratio for code 14 wrong");
  chk_long_ratio: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (!mid_col && code == 5'h1b) |-> base_ratio == 18'h2_7100) // R9
    else $error("top long ratio wrong");
endmodule
`default_nettype wire

/* File: src/afd_rate_gen.sv */
// output sample strobe at modulator rate over the effective ratio
// assumes ratio is registered on ref_clk and is at least two
`timescale 1ns/1ps
`default_nettype none
module afd_rate_gen
  import afd_pkg::*;
(
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic [17:0] ratio,
  output logic mod_tick,
  output logic sample_strobe
);
  logic [17:0] cnt; // modulator ticks in current sample
  logic [17:0] last_ratio; // detects a ratio change
  logic [17:0] gap; // helper for the period check
  wire ratio_changed = (ratio != last_ratio);
  wire wrap = mod_tick && (cnt == ratio - 18'h0_0001);
  // ==========================================================
  // divide by two gives the modulator tick
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      mod_tick <= 1'b0;
    else
      mod_tick <= !mod_tick; // R13
  end
  // ==========================================================
  // ratio counter restarts on a new ratio so no stale period leaks
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt <= '0;
      last_ratio <= '0;
      sample_strobe <= 1'b0;
    end
    else
    begin
      last_ratio <= ratio;
      sample_strobe <= wrap && !ratio_changed; // R6
      if (ratio_changed || wrap)
        cnt <= '0;
      else if (mod_tick)
        cnt <= cnt + 18'h0_0001;
    end
  end
  // ==========================================================
  // helper: ticks between strobes
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
      gap <= '0;
    else if (ratio_changed || sample_strobe)
      gap <= '0;
    else if (mod_tick)
      gap <= gap + 18'h0_0001;
  end
  chk_sample_gap: assert property (@(posedge ref_clk) disable iff (!reset_n)
    (sample_strobe && ratio == $past(ratio) && gap != 18'h0_0000) |-> gap == ratio) // R6
    else $error("sample period differs from ratio");
  chk_mod_tick: assert property (@(posedge ref_clk) disable iff (!reset_n)
    mod_tick |=> !mod_tick ##1 mod_tick) // R13
    else $error("modulator tick not every second clock");
endmodule
`default_nettype wire

/* File: verification/tb.sv */
// self-checking bench for the filter mode and ratio decode block
// assumes afd_top with its apb slave, one 100 MHz clock and the afd_pkg
`timescale 1ns/1ps
`default_nettype none
module tb
  import afd_pkg::*;
;
  // ==========================================================
  // clock, reset and apb drive
  logic ref_clk = 1'b0;
  logic reset_n = 1'b0; // held low for the first 20 cycles
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [3:0] pstrb = 4'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [1:0] filter_path;
  logic first_stage_sinc3;
  logic coef_programmable;
  logic [17:0] eff_ratio;
  logic [2:0] stage_bypass;
  logic wideband_stage_order;
  logic [2:0] start_delay;
  logic sample_strobe;
  int mismatches = 0;
  int total_checks = 0;
  int cycles = 0; // hang guard
  int seed = 32'h75cd;
  // normal speed ratio per code, kept apart from the design's own tables
  int norm_ratio [0:31] = '{32, 64, 128, 256, 512, 1024, 2048, 4096, 12, 16, 24, 32, 64, 128,
    256, 333, 512, 667, 1024, 1333, 2048, 2667, 4096, 5333, 26667, 32000, 96000, 160000,
    26656, 32000, 96000, 160000};

  afd_top dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .filter_path(filter_path),
    .first_stage_sinc3(first_stage_sinc3), .coef_programmable(coef_programmable),
    .eff_ratio(eff_ratio), .stage_bypass(stage_bypass),
    .wideband_stage_order(wideband_stage_order), .start_delay(start_delay),
    .sample_strobe(sample_strobe));

  // ==========================================================
  // clock generation and hang guard
  initial
  begin
    forever #5 ref_clk = ~ref_clk;
  end

  // a stuck handshake must still end the run with a verdict
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      stop_test();
    end
  end

  // ==========================================================
  // verdict and comparison
  task automatic stop_test();
    if (mismatches == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // ==========================================================
  // apb master: setup, access, hold until pready is seen at an edge
  task automatic apb(input logic wr, input logic [5:0] idx, input logic [31:0] wd,
    input logic [3:0] st, output logic [31:0] rd, output logic err);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= {idx, 2'b00};
    pwdata <= wd;
    pstrb <= st;
    @(posedge ref_clk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge ref_clk);
      n++;
    end
    while (pready !== 1'b1 && n < 50);
    rd = prdata;
    err = pslverr;
    chk("pready", {31'h0, pready}, 32'h0000_0001);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // upper data bits and upper strobes are random: the slave must drop them
  task automatic wr(input logic [5:0] idx, input logic [7:0] d);
    logic [31:0] r;
    logic [31:0] rd;
    logic err;
    r = $random(seed);
    apb(1'b1, idx, {r[31:8], d}, {r[3:1], 1'b1}, rd, err);
    chk("write_err", {31'h0, err}, 32'h0000_0000);
  endtask

  task automatic rdchk(input logic [5:0] idx, input logic [31:0] exp, input logic eerr);
    logic [31:0] rd;
    logic err;
    apb(1'b0, idx, 32'h0000_0000, 4'h0, rd, err);
    chk("rdata", rd, exp);
    chk("slverr", {31'h0, err}, {31'h0, eerr});
  endtask

  // ==========================================================
  // expected decode, worked out from the ratio tables
  function automatic logic [17:0] exp_ratio(input logic [4:0] c, input logic [1:0] s,
    input logic [7:0] g);
    int r;
    r = norm_ratio[c];
    if (s == 2'h1 && c >= 14)
      r = (c == 14) ? 167 : (c < 24) ? norm_ratio[c - 1] : (c == 28) ? 13334 : r / 2;
    if (c < 8)
      r = r >> (int'(g[2]) + int'(g[1]));
    return r[17:0];
  endfunction

  // outputs are registered one edge after the register lands, so wait three
  task automatic check_decode(input logic [2:0] v, input logic [4:0] c, input logic [1:0] s,
    input logic [7:0] g);
    logic [1:0] p;
    p = (c < 8) ? 2'h0 : (c < 24) ? 2'h1 : (c < 28) ? 2'h2 : 2'h3;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("filter_path", filter_path, p);
    chk("eff_ratio", eff_ratio, exp_ratio(c, s, g));
    chk("sinc3", first_stage_sinc3, p != 2'h0 && v == 3'h1);
    chk("coef", coef_programmable, p == 2'h0 && v == 3'h7);
    chk("stage_bypass", stage_bypass, g[2:0]);
    chk("order", wideband_stage_order, g[3]);
    chk("start_delay", start_delay, g[6:4]);
    // status word: coef, sinc3, path and ratio of the live decode
    rdchk(AFD_IDX_STATUS, {10'h000, p == 2'h0 && v == 3'h7, p != 2'h0 && v == 3'h1, p,
      exp_ratio(c, s, g)}, 1'b0);
  endtask

  // ==========================================================
  // main sequence
  initial
  begin
    logic [31:0] r;
    logic [31:0] rd;
    logic err;
    logic [4:0] c;
    logic [1:0] s;
    logic [7:0] g;
    int n;
    repeat (20) @(posedge ref_clk);
    reset_n <= 1'b1;
    // reset values, then an unmapped index
    rdchk(AFD_IDX_MODE, 32'h0000_0000, 1'b0);
    rdchk(AFD_IDX_STAGE, 32'h0000_0001, 1'b0);
    check_decode(3'h0, 5'h00, 2'h2, 8'h01);
    rdchk(6'h3f, 32'h0000_0000, 1'b1);
    // reserved bit 7 never sticks; a write without byte strobe is dropped
    wr(AFD_IDX_STAGE, 8'hff);
    rdchk(AFD_IDX_STAGE, 32'h0000_007f, 1'b0);
    apb(1'b1, AFD_IDX_STAGE, 32'h0000_0000, 4'he, rd, err);
    rdchk(AFD_IDX_STAGE, 32'h0000_007f, 1'b0);
    // every code in both columns first, then fully random settings
    for (int i = 0; i < 110; i++)
    begin
      r = $random(seed);
      c = (i < 64) ? i[4:0] : r[4:0];
      s = (i < 64) ? (i[5] ? 2'h1 : 2'h2) : r[6:5];
      g = {1'b0, r[14:8]};
      if (i % 8 == 3)
        r[23:21] = 3'h7; // corner: programmable coefficient code
      wr(AFD_IDX_SPEED, {6'h00, s});
      wr(AFD_IDX_STAGE, g);
      wr(AFD_IDX_MODE, {r[23:21], c});
      rdchk(AFD_IDX_MODE, {24'h0, r[23:21], c}, 1'b0);
      check_decode(r[23:21], c, s, g);
    end
    // strobe spacing: both fir sections off quarters 32 to 8, then sinc ratio 12
    for (int k = 0; k < 2; k++)
    begin
      wr(AFD_IDX_SPEED, 8'h02);
      wr(AFD_IDX_STAGE, 8'h06);
      wr(AFD_IDX_MODE, k ? 8'h08 : 8'h00);
      check_decode(3'h0, k ? 5'h08 : 5'h00, 2'h2, 8'h06);
      n = 0;
      do
      begin
        @(posedge ref_clk);
        n++;
      end
      while (sample_strobe !== 1'b1 && n < 2000);
      n = 0;
      do
      begin
        @(posedge ref_clk);
        n++;
      end
      while (sample_strobe !== 1'b1 && n < 2000);
      chk("strobe_gap", n, k ? 32'd24 : 32'd16);
    end
    stop_test();
  end
endmodule
`default_nettype wire
